/* File: verilog/sfr_pkg.sv */
// Purpose: Shared constants and types of the flag and status readout block
// Assumes: 16-bit command frames, MSB first
// Notes:   Identification value is arbitrary
package sfr_pkg;
  localparam int          CMD_W          = 16;
  localparam int          BYTE_W         = 8;
  localparam int          NUM_FLAG_BYTES = 8;
  localparam logic [1:0]  CLS_FLAG       = 2'h3;
  localparam logic [1:0]  CLS_LIVE       = 2'h0;
  localparam logic [4:0]  ADDR_REG       = 5'h0F;
  localparam logic [4:0]  ADDR_CAN       = 5'h10;
  localparam logic [4:0]  ADDR_IO        = 5'h11;
  localparam logic [4:0]  ADDR_SAFE      = 5'h12;
  localparam logic [4:0]  FRAME_BITS     = 5'h10;
  localparam logic [4:0]  CNT_MAX        = 5'h1F;
  localparam logic [7:0]  FLAG_RST       = 8'h00;
  localparam logic [7:0]  RESP_RST       = 8'h00;
  // Arbitrary identification value
  localparam logic [7:0]  ID_DEFAULT     = 8'hA5;

  typedef struct packed {
    logic [1:0] cls;
    logic [4:0] addr;
    logic       rd_mark;
    logic       byte_sel;
    logic [6:0] pad;
  } sfr_cmd_s;

  typedef struct packed {
    logic [7:0] can_live;
    logic [7:0] io_live;
  } sfr_live_s;
endpackage

/* File: verilog/sfr_flag_byte.sv */
// Purpose: One byte of latched failure flags with clear-on-read
// Assumes: Fault conditions arrive from outside the clock domain
// Notes:   A set outranks a clear in the same cycle
`timescale 1ns/1ns
module sfr_flag_byte #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Fault side
  input  wire logic [W-1:0] fault_cond,
  // Read side
  input  wire logic         clear,
  output logic      [W-1:0] flags_q
);
  import sfr_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] cond_q;

  // Two-stage synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '0;
      cond_q <= '0;
    end else begin
      meta_q <= fault_cond;
      cond_q <= meta_q;
    end
  end

  // Latch; clear only recovered bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q <= W'(FLAG_RST);
    end else if (clear) begin
      flags_q <= (flags_q & cond_q) | cond_q;
    end else begin
      flags_q <= flags_q | cond_q;
    end
  end

  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (reset)
    cond_q != '0 |=> (flags_q & $past(cond_q)) == $past(cond_q))
    else $error("active fault not latched");
  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (reset)
    !clear |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without read");
  AST_CLEAR_RECOVERED: assert property (@(posedge mclk) disable iff (reset)
    clear |=> flags_q == $past(cond_q))
    else $error("clear did not follow recovery");
  COV_CLEAR_BLOCKED: cover property (@(posedge mclk) disable iff (reset)
    clear && (flags_q & cond_q) != '0);
endmodule

/* File: verilog/sfr_status_readout.sv */
// Purpose: SPI readout of latched fault flags, live states and identification
// Assumes: Mode 0 framing, MSB first; 16 clocks per frame
// Notes:   Flag byte answers a command in the next frame
//
// Notes on behaviour
// - A command with class 11 returns the addressed latched failure flag byte.
// - A command with class 00 and byte select set returns live I/O levels, transceiver state or the identification byte.
// - Command bits 13 to 9 are decoded as the address of the register to return.
// - No parity check is applied, so a read is never refused for parity.
// - A detected failure sets its flag, which stays set after the failure disappears.
// - Reading a flag clears it only when its failure has recovered, otherwise it stays set.
`timescale 1ns/1ns
module sfr_status_readout #(
  parameter logic [7:0] ID_VALUE = sfr_pkg::ID_DEFAULT
) (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   reset,
  // SPI pins
  input  wire logic                                   spi_sclk,
  input  wire logic                                   spi_cs_n,
  input  wire logic                                   spi_mosi,
  output logic                                        spi_miso_o,
  output logic                                        spi_miso_oe_n,
  // Device state
  input  wire logic [7:0]                             fixed_status,
  input  wire logic [sfr_pkg::NUM_FLAG_BYTES-1:0][7:0] fault_cond,
  input  wire sfr_pkg::sfr_live_s                     live_in
);
  import sfr_pkg::*;

  logic [2:0]       sclk_q;
  logic [2:0]       cs_q;
  logic [1:0]       mosi_q;
  sfr_live_s        live_m_q;
  sfr_live_s        live_q;
  logic [CMD_W-1:0] rx_q;
  logic [CMD_W-1:0] tx_q;
  logic [4:0]       cnt_q;
  logic [7:0]       resp_q;
  logic [7:0]       resp_d;
  logic [NUM_FLAG_BYTES-1:0] clr_q;
  logic [NUM_FLAG_BYTES-1:0] clr_d;
  logic [7:0]       flags [NUM_FLAG_BYTES];
  sfr_cmd_s         cmd;
  logic [4:0]       addr_off;
  logic [2:0]       idx;
  logic             addr_ok;
  logic             frame_ok;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             cs_fall;
  logic             cs_rise;
  logic             active;

  // Pin synchronisers; stage 0 read only by stage 1
  always_ff @(posedge mclk) begin
    if (reset) begin
      sclk_q   <= 3'h0;
      cs_q     <= 3'h7;
      mosi_q   <= 2'h0;
      live_m_q <= '0;
      live_q   <= '0;
    end else begin
      sclk_q   <= {sclk_q[1:0], spi_sclk};
      cs_q     <= {cs_q[1:0], spi_cs_n};
      mosi_q   <= {mosi_q[0], spi_mosi};
      live_m_q <= live_in;
      live_q   <= live_m_q;
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_fall   = ~cs_q[1] & cs_q[2];
  assign cs_rise   = cs_q[1] & ~cs_q[2];
  assign active    = ~cs_q[1];

  // Command decode
  assign cmd      = sfr_cmd_s'(rx_q);
  assign addr_off = cmd.addr - ADDR_REG;
  assign addr_ok  = (cmd.addr >= ADDR_REG) && (cmd.addr <= ADDR_SAFE);
  assign idx      = {addr_off[1:0], cmd.byte_sel};
  // Only length and read marker qualify a frame; no parity test
  assign frame_ok = (cnt_q == FRAME_BITS) && cmd.rd_mark;

  // Flag byte latches
  genvar g;
  generate
    for (g = 0; g < NUM_FLAG_BYTES; g++) begin : g_flag
      sfr_flag_byte #(.W(BYTE_W)) u_flag (
        .mclk       (mclk),
        .reset      (reset),
        .fault_cond (fault_cond[g]),
        .clear      (clr_q[g]),
        .flags_q    (flags[g])
      );
    end
  endgenerate

  // Response byte selection
  always_comb begin
    resp_d = RESP_RST;
    clr_d  = '0;
    if (frame_ok && addr_ok) begin
      if (cmd.cls == CLS_FLAG) begin
        resp_d     = flags[idx];
        clr_d[idx] = 1'b1;
      end else if (cmd.cls == CLS_LIVE && cmd.byte_sel) begin
        case (cmd.addr)
          ADDR_CAN:  resp_d = live_q.can_live;
          ADDR_IO:   resp_d = live_q.io_live;
          ADDR_SAFE: resp_d = ID_VALUE;
          default:   resp_d = RESP_RST;
        endcase
      end
    end
  end

  // Receive shifter and bit count
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_q  <= '0;
      cnt_q <= 5'h00;
    end else if (cs_fall) begin
      cnt_q <= 5'h00;
    end else if (active && sclk_rise) begin
      rx_q  <= {rx_q[CMD_W-2:0], mosi_q[1]};
      cnt_q <= (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 5'h01;
    end
  end

  // Answer capture and clear pulse at frame end
  always_ff @(posedge mclk) begin
    if (reset) begin
      resp_q <= RESP_RST;
      clr_q  <= '0;
    end else if (cs_rise) begin
      resp_q <= resp_d;
      clr_q  <= clr_d;
    end else begin
      clr_q  <= '0;
    end
  end

  // Transmit shifter: fixed status then answer byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_q <= '0;
    end else if (cs_fall) begin
      tx_q <= {fixed_status, resp_q};
    end else if (active && sclk_fall) begin
      tx_q <= {tx_q[CMD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_o    <= tx_q[CMD_W-1];
      spi_miso_oe_n <= ~active;
    end
  end

  AST_RESP_FLAG: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && addr_ok && cmd.cls == CLS_FLAG |=> resp_q == $past(flags[idx]))
    else $error("flag byte not returned");
  AST_RESP_LIVE: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && cmd.cls == CLS_LIVE && cmd.byte_sel && cmd.addr == ADDR_SAFE
    |=> resp_q == ID_VALUE)
    else $error("identification not returned");
  AST_RESP_CAN: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && cmd.cls == CLS_LIVE && cmd.byte_sel && cmd.addr == ADDR_CAN
    |=> resp_q == $past(live_q.can_live))
    else $error("transceiver state not returned");
  AST_RESP_IO: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && cmd.cls == CLS_LIVE && cmd.byte_sel && cmd.addr == ADDR_IO
    |=> resp_q == $past(live_q.io_live))
    else $error("input levels not returned");
  AST_LIVE_UNSEL: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && cmd.cls == CLS_LIVE && !cmd.byte_sel |=> resp_q == RESP_RST)
    else $error("live read without byte select answered");
  AST_LIVE_NO_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && cmd.cls != CLS_FLAG |=> clr_q == '0)
    else $error("live read cleared a flag");
  AST_BAD_ADDR: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && !addr_ok |=> resp_q == RESP_RST && clr_q == '0)
    else $error("unmapped address answered");
  AST_READ_MARK: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && !cmd.rd_mark |=> clr_q == '0)
    else $error("read without marker acted");
  AST_BAD_LENGTH: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && cnt_q != FRAME_BITS |=> resp_q == RESP_RST && clr_q == '0)
    else $error("frame of wrong length acted");
  AST_NO_PARITY: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && cnt_q == FRAME_BITS && cmd.rd_mark && addr_ok && cmd.cls == CLS_FLAG
    |=> clr_q != '0 ##1 clr_q == '0)
    else $error("flag read refused");
  AST_CLEAR_SEL: assert property (@(posedge mclk) disable iff (reset)
    clr_q != '0 |-> $onehot(clr_q))
    else $error("more than one byte cleared");
  AST_CLEAR_ADDR: assert property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && addr_ok && cmd.cls == CLS_FLAG |=> clr_q[$past(idx)])
    else $error("wrong flag byte cleared");
  AST_RX_SHIFT: assert property (@(posedge mclk) disable iff (reset)
    active && sclk_rise && !cs_fall |=> rx_q == {$past(rx_q[CMD_W-2:0]), $past(mosi_q[1])})
    else $error("command bit not taken");
  AST_MISO_LOAD: assert property (@(posedge mclk) disable iff (reset)
    cs_fall |=> tx_q == {$past(fixed_status), $past(resp_q)})
    else $error("answer not loaded at frame start");

  COV_FLAG_READ: cover property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && addr_ok && cmd.cls == CLS_FLAG);
  COV_LIVE_READ: cover property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && cmd.cls == CLS_LIVE && cmd.addr == ADDR_IO);
  COV_SHORT_FRAME: cover property (@(posedge mclk) disable iff (reset)
    cs_rise && cnt_q != FRAME_BITS);
  COV_ID_READ: cover property (@(posedge mclk) disable iff (reset)
    cs_rise && frame_ok && cmd.cls == CLS_LIVE && cmd.byte_sel && cmd.addr == ADDR_SAFE);
endmodule

/* File: test/sfr_host_model.sv */
// Purpose: Host SPI master model issuing 16-bit read frames
// Assumes: Mode 0, MSB first, sclk half period of 6 mclk
// Notes:   MOSI shows the inverse of its last bit while deselected
`timescale 1ns/1ns
module sfr_host_model (
  // Clock
  input  wire logic        mclk,
  // SPI pins
  input  wire logic        miso,
  input  wire logic        miso_oe_n,
  output logic             sclk,
  output logic             cs_n,
  output logic             mosi,
  // Result
  output logic [15:0]      rsp,
  output logic             done
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    done = 1'b0;
    rsp  = 16'h0000;
  end

  // Class, address, read mark and byte select go out MSB first
  task automatic xfer(input logic [15:0] cmd, input bit extra);
    @(negedge mclk);
    cs_n <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      mosi <= cmd[k];
      repeat (6) @(negedge mclk);
      rsp[k] <= miso_oe_n ? 1'bx : miso;
      sclk <= 1'b1;
      repeat (6) @(negedge mclk);
      sclk <= 1'b0;
    end
    // One clock too many makes an over-long frame
    if (extra) begin
      mosi <= 1'b0;
      repeat (6) @(negedge mclk);
      sclk <= 1'b1;
      repeat (6) @(negedge mclk);
      sclk <= 1'b0;
    end
    repeat (6) @(negedge mclk);
    cs_n <= 1'b1;
    mosi <= ~cmd[0];
    repeat (8) @(negedge mclk);
    done <= 1'b1;
    @(negedge mclk);
    done <= 1'b0;
  endtask
endmodule

/* File: test/sfr_status_readout_tb.sv */
// Purpose: Self-checking bench of the flag and status readout
// Assumes: Answer byte comes back in the following frame
// Notes:   Identification value is arbitrary
`timescale 1ns/1ns
module sfr_status_readout_tb;
  import sfr_pkg::*;
  localparam logic [7:0] ID_T = 8'h3C;
  logic            mclk, reset, sclk, cs_n, mosi, miso, oe_n, done;
  logic [7:0]      fixed, prev;
  logic [7:0][7:0] cond, flg;
  sfr_live_s       live;
  logic [15:0]     rsp, e;
  logic [15:0]     expq[$];
  bit              extra_b;
  int              n_fail, checked;

  sfr_status_readout #(.ID_VALUE(ID_T)) DUT (.mclk(mclk), .reset(reset), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe_n(oe_n),
    .fixed_status(fixed), .fault_cond(cond), .live_in(live));
  sfr_host_model host (.mclk(mclk), .miso(miso), .miso_oe_n(oe_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .rsp(rsp), .done(done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [15:0] mk(logic [1:0] c, logic [4:0] a, logic r, logic b);
    return {c, a, r, b, 7'h00};
  endfunction

  // Works out the answer, notes it and runs the frame
  task automatic send(input logic [15:0] cmd);
    logic [7:0] ans;
    int         idx;
    logic       ok;
    ans = 8'h00;
    idx = (int'(cmd[13:9]) - int'(ADDR_REG)) * 2 + int'(cmd[7]);
    ok  = cmd[8] && !extra_b;
    if (ok && cmd[15:14] == CLS_FLAG && cmd[13:9] >= ADDR_REG && cmd[13:9] <= ADDR_SAFE) begin
      ans = flg[idx];
      flg[idx] = cond[idx];
    end else if (ok && cmd[7] && cmd[15:14] == CLS_LIVE) begin
      case (cmd[13:9])
        ADDR_CAN:  ans = live.can_live;
        ADDR_IO:   ans = live.io_live;
        ADDR_SAFE: ans = ID_T;
        default:   ans = 8'h00;
      endcase
    end
    fixed = 8'($urandom);
    expq.push_back({fixed, prev});
    prev = ans;
    host.xfer(cmd, extra_b);
  endtask

  task automatic fault(input int i, input logic [7:0] pat, input bit hold);
    @(negedge mclk);
    cond[i] = pat;
    flg[i] = flg[i] | pat;
    repeat (6) @(negedge mclk);
    if (!hold) cond[i] = 8'h00;
    repeat (4) @(negedge mclk);
  endtask

  always @(posedge mclk) begin
    if (done === 1'b1) begin
      e = expq.pop_front();
      checked++;
      if (rsp !== e) begin
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, rsp, e);
      end
    end
  end

  task automatic final_report;
    $display("checks=%0d fails=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    fixed = 8'h00;
    prev = 8'h00;
    cond = '0;
    flg = '0;
    n_fail = 0;
    checked = 0;
    void'($urandom(18013));
    extra_b = 1'b0;
    live = sfr_live_s'(16'($urandom));
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    // Each flag byte latches a pulse, then clears once recovered
    for (int i = 0; i < NUM_FLAG_BYTES; i++) begin
      fault(i, 8'($urandom) | 8'h01, 1'b0);
      send(mk(CLS_FLAG, ADDR_REG + 5'(i / 2), 1'b1, 1'(i % 2)));
      send(mk(CLS_FLAG, ADDR_REG + 5'(i / 2), 1'b1, 1'(i % 2)));
    end
    // An active fault survives its read
    fault(2, 8'h81, 1'b1);
    send(mk(CLS_FLAG, ADDR_CAN, 1'b1, 1'b0));
    send(mk(CLS_FLAG, ADDR_CAN, 1'b1, 1'b0));
    cond[2] = 8'h00;
    repeat (4) @(negedge mclk);
    send(mk(CLS_FLAG, ADDR_CAN, 1'b1, 1'b0));
    // Refused frames leave the flag alone; a frame without read mark is refused
    fault(7, 8'h5A, 1'b0);
    send(mk(CLS_FLAG, ADDR_SAFE, 1'b0, 1'b1));
    // An over-long frame is refused and clears nothing
    extra_b = 1'b1;
    send(mk(CLS_FLAG, ADDR_SAFE, 1'b1, 1'b1));
    extra_b = 1'b0;
    send(mk(2'h1, ADDR_SAFE, 1'b1, 1'b1));
    send(mk(CLS_FLAG, ADDR_SAFE, 1'b1, 1'b1));
    // Live levels, identification and refused live selects
    for (int a = 15; a <= 19; a++) begin
      send(mk(CLS_LIVE, 5'(a), 1'b1, 1'b1));
      send(mk(CLS_LIVE, 5'(a), 1'b1, 1'b0));
    end
    send(16'h0000);
    final_report();
  end
endmodule
